//--- hw/rx_track_map.svh
// Purpose: Offsets, field positions and constants of the tracking registers.
// Assumes: Included by bare name from the design files.
// Notes: Definitions only.
`ifndef RX_TRACK_MAP_SVH
`define RX_TRACK_MAP_SVH
`define RX_TRACKING_INTERVAL_ADDR 6'h13
`define RX_TRACKING_OFFSET_ADDR 6'h14
`define TRACK_INTERVAL_PRF16 32'h01F00000
`define TRACK_INTERVAL_PRF64 32'h01FC0000
`define TRACK_OFFSET_WIDTH 19
`define TRACK_OFFSET_MSB 18
`define RESAMPLER_LSB 24
`define RESAMPLER_MSB 31
`define PHASE_MSB 6
`define PHASE_LSB 32
`define PHASE_WIDTH 7
`define TRACK_INTERVAL_RESET 32'h00000000
`define TRACK_OFFSET_RESET 40'h0000000000
`define ADDR_WIDTH 6
`define BYTE_SEL_WIDTH 3
`endif

//--- hw/rx_track_pkg.sv
// Purpose: Types shared by the tracking register bank.
// Assumes: Nothing beyond the map header.
// Notes: Types only.
package rx_track_pkg;
   typedef enum logic [1:0] {
      PRF_16 = 2'h1,
      PRF_64 = 2'h2
   } prf_t;
endpackage

//--- hw/rx_track_bank.sv
// Purpose: One buffered copy of the tracking interval and offset.
// Assumes: Capture strobe is a same-clock one-cycle pulse.
// Notes: Two copies form the swinging set.
`timescale 1ns/10ps
`include "rx_track_map.svh"
module rx_track_bank (
   // Clock and reset.
   input wire logic CORE_CLK,
   input wire logic RESET_N,
   // Capture.
   input wire logic capture,
   input wire logic [31:0] interval_in,
   input wire logic [39:0] offset_in,
   // Held values.
   output logic [31:0] interval_value,
   output logic [39:0] offset_value
);
   logic [31:0] next_interval_value;
   logic [39:0] next_offset_value;

   always_comb begin
      next_interval_value = interval_value;
      next_offset_value = offset_value;
      if (capture) begin
         next_interval_value = interval_in;
         next_offset_value = offset_in;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         interval_value <= `TRACK_INTERVAL_RESET;
         offset_value <= `TRACK_OFFSET_RESET;
      end else begin
         interval_value <= next_interval_value;
         offset_value <= next_offset_value;
      end
   end
endmodule // rx_track_bank

//--- hw/rx_clock_offset_report.sv
// Purpose: Read-only receiver clock offset report registers.
// Assumes: Receiver status inputs are on CORE_CLK; host reads by address.
// Notes: Two banks swing; the host sees the bank selected for reading.
`timescale 1ns/10ps
`include "rx_track_map.svh"
// Notes on behaviour
// - Refresh only on successful frame demodulation.
// - Interval is 32-bit constant chosen by PRF.
// - Offset is 19-bit signed in low bits.
// - Host divides signed offset by interval.
// - Positive offset means remote clock faster.
// - Resampler delay sits in bits 31 to 24.
// - Phase at timestamp in fifth octet, 7 bits.
// - Both registers read-only, swing with buffer set.
module rx_clock_offset_report (
   // Clock and reset.
   input wire logic CORE_CLK,
   input wire logic RESET_N,
   // Receiver status.
   input wire logic DEMOD_DONE_OK,
   input wire logic PRF_IS_64,
   input wire logic [18:0] DRIFT_MEASURED,
   input wire logic [7:0] RESAMPLER_DELAY,
   input wire logic [6:0] CARRIER_PHASE,
   input wire logic STAMP_TAKEN,
   // Swinging set control.
   input wire logic FILL_BANK,
   input wire logic READ_BANK,
   // Host read port.
   input wire logic [5:0] RD_ADDR,
   input wire logic [2:0] RD_BYTE,
   output logic [7:0] RD_DATA,
   output logic RD_HIT
);
   rx_track_pkg::prf_t prf;
   logic [6:0] carrier_phase_at_stamp;
   logic [6:0] next_carrier_phase_at_stamp;
   logic [31:0] tracking_interval_value;
   logic [39:0] tracking_offset_value;
   logic [18:0] drift_field;
   logic [7:0] resampler_delay;
   logic [1:0] capture_bank;
   logic [31:0] iv [2];
   logic [39:0] ov [2];
   logic [31:0] shown_interval;
   logic [39:0] shown_offset;
   logic hit_interval;
   logic hit_offset;
   logic [7:0] next_rd_data;
   logic [39:0] sel_word;

   function automatic logic [7:0] pick_byte(input logic [39:0] w,
                                            input logic [2:0] b);
      logic [7:0] r;
      r = 8'h00;
      case (b)
         3'h0: r = w[7:0];
         3'h1: r = w[15:8];
         3'h2: r = w[23:16];
         3'h3: r = w[31:24];
         3'h4: r = w[39:32];
         default: r = 8'h00;
      endcase
      return r;
   endfunction

   // Gives the interval constant that belongs to one PRF setting.
   function automatic logic [31:0] interval_for(
      input rx_track_pkg::prf_t p
   );
      logic [31:0] r;
      r = `TRACK_INTERVAL_PRF16;
      unique case (p)
         rx_track_pkg::PRF_64: r = `TRACK_INTERVAL_PRF64;
         default: r = `TRACK_INTERVAL_PRF16;
      endcase
      return r;
   endfunction

   // Tells whether a host address selects the given register.
   function automatic logic addr_is(input logic [5:0] a,
                                    input logic [5:0] t);
      logic r;
      r = (a == t);
      return r;
   endfunction

   // Tells whether a finished frame lands in the given bank.
   function automatic logic fill_strobe(input logic done,
                                        input logic fill,
                                        input logic idx);
      logic r;
      r = done && (fill == idx);
      return r;
   endfunction

   assign prf = PRF_IS_64 ? rx_track_pkg::PRF_64 : rx_track_pkg::PRF_16;

   always_comb begin
      tracking_interval_value = interval_for(prf);
   end

   always_comb begin
      next_carrier_phase_at_stamp = carrier_phase_at_stamp;
      if (STAMP_TAKEN) begin
         next_carrier_phase_at_stamp = CARRIER_PHASE;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         carrier_phase_at_stamp <= 7'h00;
      end else begin
         carrier_phase_at_stamp <= next_carrier_phase_at_stamp;
      end
   end

   // Drift keeps its sign bit; the host divides it by the interval.
   assign drift_field = DRIFT_MEASURED;
   assign resampler_delay = RESAMPLER_DELAY;

   // Offset word: phase octet on top, then delay, reserved zero, signed drift.
   always_comb begin
      tracking_offset_value = `TRACK_OFFSET_RESET;
      tracking_offset_value[`TRACK_OFFSET_MSB:0] = drift_field;
      tracking_offset_value[`RESAMPLER_MSB:`RESAMPLER_LSB] =
         resampler_delay;
      tracking_offset_value[`PHASE_LSB +: `PHASE_WIDTH] =
         carrier_phase_at_stamp;
   end

   // Only a successful frame refreshes a bank, and only the one to fill.
   always_comb begin
      capture_bank[0] = fill_strobe(DEMOD_DONE_OK, FILL_BANK, 1'b0);
      capture_bank[1] = fill_strobe(DEMOD_DONE_OK, FILL_BANK, 1'b1);
   end

   for (genvar g = 0; g < 2; g++) begin : g_bank
      rx_track_bank u_bank (
         .CORE_CLK(CORE_CLK),
         .RESET_N(RESET_N),
         .capture(capture_bank[g]),
         .interval_in(tracking_interval_value),
         .offset_in(tracking_offset_value),
         .interval_value(iv[g]),
         .offset_value(ov[g])
      );
   end

   // The host sees only the bank that the swap logic presents for reading.
   always_comb begin
      shown_interval = iv[READ_BANK];
      shown_offset = ov[READ_BANK];
   end

   always_comb begin
      hit_interval = addr_is(RD_ADDR, `RX_TRACKING_INTERVAL_ADDR);
      hit_offset = addr_is(RD_ADDR, `RX_TRACKING_OFFSET_ADDR);
   end

   assign RD_HIT = hit_interval || hit_offset;

   // Read only: there is no write path at all, writes are ignored.
   always_comb begin
      sel_word = 40'h0000000000;
      if (hit_interval) begin
         sel_word = {8'h00, shown_interval};
      end else if (hit_offset) begin
         sel_word = shown_offset;
      end
      next_rd_data = pick_byte(sel_word, RD_BYTE);
   end

   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         RD_DATA <= 8'h00;
      end else begin
         RD_DATA <= next_rd_data;
      end
   end
endmodule // rx_clock_offset_report

//--- tb/rx_track_asserts.sv
// Purpose: Port checks of the offset report.
// Assumes: Read data lags the address by one cycle. Notes: Bound.
`timescale 1ns/10ps
module rx_track_asserts (
   // Read port.
   input wire logic CORE_CLK,
   input wire logic RESET_N,
   input wire logic [5:0] RD_ADDR,
   input wire logic [2:0] RD_BYTE,
   input wire logic [7:0] RD_DATA,
   input wire logic RD_HIT
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RESET_N);
   wire logic iv = RD_ADDR == 6'h13;
   wire logic of = RD_ADDR == 6'h14;
   property p_hit; RD_HIT == (iv || of); endproperty
   a_hit: assert property (p_hit) else $error("hit");
   property p_miss; !(iv || of) |=> RD_DATA == 8'h00; endproperty
   a_miss: assert property (p_miss) else $error("miss");
   property p_big; RD_BYTE > 3'h4 |=> RD_DATA == 8'h00; endproperty
   a_big: assert property (p_big) else $error("big");
   property p_i4; iv && RD_BYTE == 3'h4 |=> RD_DATA == 8'h00; endproperty
   a_i4: assert property (p_i4) else $error("i4");
   property p_ilo; iv && RD_BYTE < 3'h2 |=> RD_DATA == 8'h00; endproperty
   a_ilo: assert property (p_ilo) else $error("ilo");
   property p_ihi; iv && RD_BYTE == 3'h3 |=> RD_DATA[7:1] == 7'h00; endproperty
   a_ihi: assert property (p_ihi) else $error("ihi");
   property p_rsv; of && RD_BYTE == 3'h2 |=> RD_DATA[7:3] == 5'h00; endproperty
   a_rsv: assert property (p_rsv) else $error("rsv");
   property p_ph; of && RD_BYTE == 3'h4 |=> !RD_DATA[7]; endproperty
   a_ph: assert property (p_ph) else $error("ph");
   c_iv: cover property (iv ##1 RD_DATA == 8'hFC);
   c_of: cover property (of && RD_BYTE == 3'h3 ##1 RD_DATA != 8'h00);
   c_ms: cover property (!(iv || of) ##1 RD_DATA == 8'h00);
endmodule // rx_track_asserts
bind rx_clock_offset_report rx_track_asserts rx_track_asserts_i (.CORE_CLK,
   .RESET_N, .RD_ADDR, .RD_BYTE, .RD_DATA, .RD_HIT);

//--- tb/rx_host_model.sv
// Purpose: Host that reads report bytes.
// Assumes: One read per cycle. Notes: No write path is used.
`timescale 1ns/10ps
module rx_host_model (
   // Host read port.
   input wire logic CORE_CLK,
   output logic [5:0] RD_ADDR = 6'h00,
   output logic [2:0] RD_BYTE = 3'h0,
   output logic req = 1'b0
);
   // Issues one read and never writes reserved bits.
   task automatic rd(logic [5:0] a, logic [2:0] b, logic v);
      @(posedge CORE_CLK);
      #1 {RD_ADDR, RD_BYTE, req} = {a, b, v};
   endtask
endmodule // rx_host_model

//--- tb/rx_clock_offset_report_test.sv
// Purpose: Reads both banks around each capture.
// Assumes: Host model drives reads. Notes: Expected bytes are queued.
`timescale 1ns/10ps
module rx_clock_offset_report_test;
   logic CORE_CLK = 0, RESET_N = 0, DEMOD_DONE_OK = 0, STAMP_TAKEN = 0;
   logic PRF_IS_64 = 0, FILL_BANK = 0, READ_BANK = 0, RD_HIT, req, vd = 0;
   logic [18:0] DRIFT_MEASURED = 0;
   logic [7:0] RESAMPLER_DELAY = 0, RD_DATA, q[$];
   logic [6:0] CARRIER_PHASE = 0;
   logic [5:0] RD_ADDR;
   logic [2:0] RD_BYTE;
   logic [127:0] bk[2] = '{default: 0};
   int errors = 0, check_count = 0, seed = 35;
   always #50 CORE_CLK = ~CORE_CLK;
   rx_clock_offset_report rx_clock_offset_report_i (.CORE_CLK(CORE_CLK),
      .RESET_N(RESET_N), .DEMOD_DONE_OK(DEMOD_DONE_OK),
      .PRF_IS_64(PRF_IS_64), .DRIFT_MEASURED(DRIFT_MEASURED),
      .RESAMPLER_DELAY(RESAMPLER_DELAY), .CARRIER_PHASE(CARRIER_PHASE),
      .STAMP_TAKEN(STAMP_TAKEN), .FILL_BANK(FILL_BANK),
      .READ_BANK(READ_BANK), .RD_ADDR(RD_ADDR), .RD_BYTE(RD_BYTE),
      .RD_DATA(RD_DATA), .RD_HIT(RD_HIT));
   rx_host_model rx_host_model_i (.CORE_CLK(CORE_CLK), .RD_ADDR(RD_ADDR),
      .RD_BYTE(RD_BYTE), .req(req));
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      check_count++;
      if (s !== e) $display("[FAIL] %0t got %h want %h", $time, s, e);
      errors += int'(s !== e);
   endtask
   task automatic stop_test;
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge CORE_CLK) vd <= req;
   always @(negedge CORE_CLK) if (vd) chk(RD_DATA, q.pop_front());
   // Pulses one strobe, then reads every byte of four addresses per bank.
   task automatic step(ref logic s);
      s = 1;
      @(posedge CORE_CLK);
      #1 s = 0;
      for (int n = 0; n < 64; n++) begin
         q.push_back(n[2:0] < 5 && ^n[4:3] ?
            bk[n[5]][64*n[3]+8*n[2:0]+:8] : 8'h00);
         rx_host_model_i.rd(6'h12 + 6'(n[4:3]), n[2:0], 1'b1);
         READ_BANK = n[5];
      end
      rx_host_model_i.rd(6'h00, 3'h0, 1'b0);
   endtask
   initial begin
      #251 RESET_N = 1;
      for (int k = 0; k < 4; k++) begin
         {FILL_BANK, PRF_IS_64, DRIFT_MEASURED} = {k[0], 20'($random(seed))};
         {RESAMPLER_DELAY, CARRIER_PHASE} = 15'($random(seed));
         step(STAMP_TAKEN);
         bk[FILL_BANK] = {32'h0, PRF_IS_64 ? 32'h01FC0000 : 32'h01F00000,
            25'h0, CARRIER_PHASE, RESAMPLER_DELAY, 5'h00, DRIFT_MEASURED};
         CARRIER_PHASE = 7'($random(seed));
         step(DEMOD_DONE_OK);
      end
      stop_test();
   end
   initial begin
      #200000 errors++;
      stop_test();
   end
endmodule // rx_clock_offset_report_test
